// ---- hdl/ops_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ops_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,       // System clock
	input  wire logic         rst,       // Async reset, active high
	input  wire logic         in_valid,  // Write request
	output logic              in_ready,  // Not full
	input  wire logic [W-1:0] in_data,   // Write word
	output logic              out_valid, // Not empty
	input  wire logic         out_ready, // Drain accepts
	output logic [W-1:0]      out_data   // Head word
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [AW:0]   cnt_ff, nxt_cnt;
	logic          push, pop;

	// Handshake terms
	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rp_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and fill level next values
	always_comb begin
		nxt_wp  = push ? AW'(wp_ff + 1'b1) : wp_ff;
		nxt_rp  = pop ? AW'(rp_ff + 1'b1) : rp_ff;
		nxt_cnt = AW'(0) + cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage, one entry per index
	for (genvar i = 0; i < DEPTH; i++) begin : g_mem
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				mem_ff[i] <= '0;
			end else if (push && wp_ff == AW'(i)) begin
				mem_ff[i] <= in_data;
			end
		end
	end

endmodule // ops_fifo

// ---- hdl/ops_pkg.sv ----
// Shared constants, types and timing for the one-pin voltage-set receiver
package ops_pkg;

	// Clock and counter widths
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          CNT_W         = 13;
	localparam logic [12:0] CNT_MAX       = 13'h1FFF;

	// Times in their own unit
	localparam int START_TIME_NS  = 2000;
	localparam int EOS_TIME_NS    = 2000;
	localparam int ACK_VALID_NS   = 2000;
	localparam int STARTUP_NS     = 170000;
	localparam int TIMEOUT_NS     = 520000;
	localparam int ACK_PULSE_NS   = 520000;

	// Least times round up, longest times round down
	localparam logic [12:0] START_CYC = CNT_W'((START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [12:0] EOS_CYC   = CNT_W'((EOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [12:0] ACK_VALID_CYC = CNT_W'((ACK_VALID_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam logic [12:0] STARTUP_CYC = CNT_W'((STARTUP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam logic [12:0] TIMEOUT_CYC_DEF   = CNT_W'(TIMEOUT_NS / CLK_PERIOD_NS);
	localparam logic [12:0] ACK_PULSE_CYC_DEF = CNT_W'(ACK_PULSE_NS / CLK_PERIOD_NS);

	// Own address: value is arbitrary
	localparam logic [7:0] DEV_ADDR_DEF = 8'h5A;

	// Frame layout and register select codes
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [1:0] SEL_CONV1  = 2'h0;
	localparam logic [1:0] SEL_CONV2  = 2'h2;
	localparam logic [4:0] VOLT_RST   = 5'h00;
	localparam int         FIFO_DEPTH = 16;

	// Data byte, top bit first
	typedef struct packed {
		logic       ack_request_flag;
		logic       reg_select_hi;
		logic       reg_select_lo;
		logic [4:0] value;
	} ops_data_t;

	// Receiver states, one-hot
	typedef enum logic [7:0] {
		ST_OFF   = 8'h01,
		ST_IDLE  = 8'h02,
		ST_START = 8'h04,
		ST_LOW   = 8'h08,
		ST_HIGH  = 8'h10,
		ST_EOS   = 8'h20,
		ST_ACKW  = 8'h40,
		ST_ACK   = 8'h80
	} ops_state_t;

endpackage

// ---- hdl/ops_rx.sv ----
// One-pin voltage-set receiver with mode selection and acknowledge pull-down
//
// Contract
// - address byte then data byte, MSB first
// - data byte: ack flag, select, five-bit value
// - flag set means acknowledge requested
// - rate-free bit detection, 1.7 to 160 kbps
// - bit spans falling edge to falling edge
// - bit value from two-to-one time ratio
// - acknowledge needs flag, address match, 16 bits
// - pull-down after valid delay, at most 520 us
// - mismatch or bad frame leaves pull-down off
// - line high forces PWM at once
// - forced PWM held during reception
// - long low times out into power-save
// - mode change acts on both converters
// - power-save timeout at most 520 us
// - active on either enable, ready after 170 us
// - select 00 converter 1, 10 converter 2
`timescale 1ns/1ps
module ops_rx
	import ops_pkg::*;
#(
	parameter logic [7:0]  DEV_ADDR      = DEV_ADDR_DEF,      // Own address, arbitrary
	parameter logic [12:0] TIMEOUT_CYC   = TIMEOUT_CYC_DEF,   // Power-save timeout
	parameter logic [12:0] ACK_PULSE_CYC = ACK_PULSE_CYC_DEF, // Acknowledge pulse length
	parameter int          FIFO_W        = 8,                 // Queued word width
	parameter int          FIFO_D        = FIFO_DEPTH         // Queued words
) (
	input  wire logic       clk,                   // 10 MHz clock
	input  wire logic       rst,                   // Async reset, active high
	input  wire logic       line_in,               // Mode/data pin level
	output logic            line_out,              // Pin drive level, always low
	output logic            line_oe,               // Acknowledge pull-down on
	input  wire logic       converter1_enable_pin, // Converter 1 enable
	input  wire logic       converter2_enable_pin, // Converter 2 enable
	input  wire logic       apply_ready,           // Voltage update may be taken
	output logic            forced_pwm,            // Both converters forced PWM
	output logic            rx_ready,              // Receiver past start-up
	output logic [4:0]      conv1_voltage_setting, // Converter 1 code
	output logic [4:0]      conv2_voltage_setting  // Converter 2 code
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	ops_state_t  state_ff, nxt_state;
	logic [12:0] cnt_ff, nxt_cnt;
	logic [12:0] low_len_ff, nxt_low_len;
	logic [2:0]  bits_ff, nxt_bits;
	logic [7:0]  shift_ff, nxt_shift;
	logic [7:0]  addr_ff, nxt_addr;
	logic        byte1_ff, nxt_byte1;
	logic        line_q_ff;
	logic [12:0] low_run_ff, nxt_low_run;
	logic        psave_ff, nxt_psave;
	logic [4:0]  conv1_ff, nxt_conv1;
	logic [4:0]  conv2_ff, nxt_conv2;
	logic        fall, rise, active, timeout_hit;
	logic        is_one, is_zero, addr_ok, push;
	logic [12:0] cnt_inc;
	ops_data_t   fifo_in, fifo_out;
	logic        fifo_in_ready, fifo_out_valid, pop;

	////////////////////////////////////////////////////////////////////////////
	// Line edges and bit decision

	assign fall = line_q_ff & ~line_in;
	assign rise = ~line_q_ff & line_in;

	assign active = converter1_enable_pin | converter2_enable_pin;

	assign is_one  = ({1'b0, cnt_ff} >= {low_len_ff, 1'b0});
	assign is_zero = ({1'b0, low_len_ff} >= {cnt_ff, 1'b0});

	assign addr_ok = (addr_ff == DEV_ADDR);
	assign cnt_inc = (cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 13'h0001;

	assign timeout_hit = ~line_in & ~line_oe & (low_run_ff == TIMEOUT_CYC - 13'h0001);

	////////////////////////////////////////////////////////////////////////////
	// Receiver state machine

	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_inc;
		nxt_low_len = low_len_ff;
		nxt_bits    = bits_ff;
		nxt_shift   = shift_ff;
		nxt_addr    = addr_ff;
		nxt_byte1   = byte1_ff;
		push        = 1'b0;
		case (state_ff)
			ST_OFF: begin
				if (cnt_ff == STARTUP_CYC - 13'h0001) begin
					nxt_state = ST_IDLE;
					nxt_cnt   = '0;
				end
			end
			ST_IDLE: begin
				nxt_bits  = '0;
				nxt_byte1 = 1'b0;
				if (fall) begin
					nxt_state = ST_LOW;
					nxt_cnt   = '0;
				end
			end
			ST_START: begin
				if (fall) begin
					nxt_cnt   = '0;
					nxt_state = (cnt_ff >= START_CYC) ? ST_LOW : ST_IDLE;
				end
			end
			ST_LOW: begin
				if (rise) begin
					nxt_low_len = cnt_ff;
					nxt_state   = ST_HIGH;
					nxt_cnt     = '0;
				end
			end
			ST_HIGH: begin
				if (fall) begin
					nxt_cnt   = '0;
					nxt_shift = {shift_ff[6:0], is_one};
					nxt_bits  = bits_ff + 3'h1;
					if (!is_one && !is_zero) begin
						nxt_state = ST_IDLE;
					end else if (bits_ff != BIT_LAST) begin
						nxt_state = ST_LOW;
					end else if (!byte1_ff) begin
						nxt_state = ST_EOS;
					end else begin
						push      = addr_ok;
						nxt_state = (addr_ok && fifo_in_ready && nxt_shift[7]) ? ST_ACKW
							: ST_EOS;
					end
				end
			end
			ST_EOS: begin
				if (rise) begin
					nxt_cnt   = '0;
					nxt_bits  = '0;
					if (!byte1_ff && cnt_ff >= EOS_CYC) begin
						nxt_addr  = shift_ff;
						nxt_byte1 = 1'b1;
						nxt_state = ST_START;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_ACKW: begin
				if (cnt_ff == ACK_VALID_CYC - 13'h0001) begin
					nxt_state = ST_ACK;
					nxt_cnt   = '0;
				end
			end
			ST_ACK: begin
				if (cnt_ff == ACK_PULSE_CYC - 13'h0001) begin
					nxt_state = ST_IDLE;
					nxt_cnt   = '0;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt   = '0;
			end
		endcase
		if (timeout_hit && state_ff != ST_OFF) begin
			nxt_state = ST_IDLE;
			push      = 1'b0;
		end
		if (!active) begin
			nxt_state = ST_OFF;
			nxt_cnt   = '0;
			push      = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff   <= ST_OFF;
			cnt_ff     <= '0;
			low_len_ff <= '0;
			bits_ff    <= '0;
			shift_ff   <= '0;
			addr_ff    <= '0;
			byte1_ff   <= 1'b0;
			line_q_ff  <= 1'b1; // Pulled-up idle level, no false edge
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			low_len_ff <= nxt_low_len;
			bits_ff    <= nxt_bits;
			shift_ff   <= nxt_shift;
			addr_ff    <= nxt_addr;
			byte1_ff   <= nxt_byte1;
			line_q_ff  <= line_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode selection

	always_comb begin
		nxt_low_run = low_run_ff;
		nxt_psave   = psave_ff;
		if (line_in) begin
			nxt_low_run = '0;
			nxt_psave   = 1'b0;
		end else if (timeout_hit) begin
			nxt_psave   = 1'b1;
		end else if (!line_oe && low_run_ff != TIMEOUT_CYC) begin
			nxt_low_run = low_run_ff + 13'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_run_ff <= '0;
			psave_ff   <= 1'b0;
		end else begin
			low_run_ff <= nxt_low_run;
			psave_ff   <= nxt_psave;
		end
	end

	assign forced_pwm = line_in | ~psave_ff;
	assign rx_ready   = (state_ff != ST_OFF);
	assign line_out   = 1'b0;
	assign line_oe    = (state_ff == ST_ACK);

	////////////////////////////////////////////////////////////////////////////
	// Frame queue and voltage registers

	assign fifo_in = ops_data_t'(nxt_shift);

	ops_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (apply_ready),
		.out_data  (fifo_out)
	);

	assign pop = fifo_out_valid & apply_ready;

	always_comb begin
		nxt_conv1 = conv1_ff;
		nxt_conv2 = conv2_ff;
		if (pop && {fifo_out.reg_select_hi, fifo_out.reg_select_lo} == SEL_CONV1) begin
			nxt_conv1 = fifo_out.value;
		end
		if (pop && {fifo_out.reg_select_hi, fifo_out.reg_select_lo} == SEL_CONV2) begin
			nxt_conv2 = fifo_out.value;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv1_ff <= VOLT_RST;
			conv2_ff <= VOLT_RST;
		end else begin
			conv1_ff <= nxt_conv1;
			conv2_ff <= nxt_conv2;
		end
	end

	assign conv1_voltage_setting = conv1_ff;
	assign conv2_voltage_setting = conv2_ff;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	ack_pulse_len_a: assert property (
		@(posedge clk) disable iff (rst) line_oe |-> (cnt_ff < ACK_PULSE_CYC))
		else $error("acknowledge pulse too long");

	ack_delay_a: assert property (
		@(posedge clk) disable iff (rst)
		$rose(line_oe) |-> $past(state_ff == ST_ACKW) && $past(cnt_ff) == ACK_VALID_CYC - 13'h0001)
		else $error("pull-down not after valid delay");

	ack_cause_a: assert property (
		@(posedge clk) disable iff (rst)
		(state_ff == ST_ACKW && $past(state_ff == ST_HIGH)) |->
			shift_ff[7] && addr_ok && byte1_ff && $past(bits_ff) == BIT_LAST)
		else $error("acknowledge without cause");

	no_ack_miss_a: assert property (
		@(posedge clk) disable iff (rst)
		line_oe |-> addr_ok && byte1_ff)
		else $error("pull-down on mismatch");

	pwm_on_high_a: assert property (
		@(posedge clk) disable iff (rst) line_in |-> forced_pwm ##1 !psave_ff)
		else $error("line high without forced PWM");

	pwm_in_frame_a: assert property (
		@(posedge clk) disable iff (rst)
		(state_ff == ST_HIGH || state_ff == ST_START) |-> forced_pwm)
		else $error("power-save during reception");

	psave_cause_a: assert property (
		@(posedge clk) disable iff (rst)
		$rose(psave_ff) |-> $past(low_run_ff) == TIMEOUT_CYC - 13'h0001 && !$past(line_in))
		else $error("power-save without timeout");

	bit_decode_a: assert property (
		@(posedge clk) disable iff (rst)
		($past(state_ff == ST_HIGH) && $past(fall) && state_ff != ST_IDLE && active) |->
			shift_ff[0] == $past(is_one))
		else $error("bit value against time ratio");

	conv1_load_a: assert property (
		@(posedge clk) disable iff (rst)
		$changed(conv1_ff) |-> $past(pop) && $past(fifo_out.value) == conv1_ff)
		else $error("converter 1 code changed without frame");

	startup_len_a: assert property (
		@(posedge clk) disable iff (rst)
		(state_ff == ST_IDLE && $past(state_ff == ST_OFF)) |->
			$past(cnt_ff) == STARTUP_CYC - 13'h0001)
		else $error("receiver ready too early");

endmodule // ops_rx

// ---- verification/ops_host.sv ----
// Host model: open-drain master that sends frames on the one-pin line
`timescale 1ns/1ps
module ops_host (
	input  wire logic clk,      // System clock
	input  wire logic line_in,  // Resolved line level
	input  wire logic fpwm,     // Forced PWM from the device
	output logic      host_low, // Host pull-down on
	output logic      pwm_lost  // Forced PWM dropped inside a frame
);
	logic busy;
	int   start_len;

	initial begin
		host_low = 1'b0;
		busy = 1'b0;
		pwm_lost = 1'b0;
		start_len = 25;
	end

	// flag a mode drop while a frame is on the line
	always @(posedge clk) begin
		if (busy && fpwm !== 1'b1) begin
			pwm_lost <= 1'b1;
		end
	end

	// Drive a level for a number of cycles, changing at the falling clock edge
	task automatic hold(input logic low, input int n);
		host_low = low;
		repeat (n) @(negedge clk);
	endtask

	task automatic send_byte(input logic [7:0] b, input logic bad);
		for (int i = 7; i >= 0; i--) begin
			if (bad && i == 0) begin
				hold(1'b1, 15);
				hold(1'b0, 15);
			end else if (b[i]) begin
				hold(1'b1, 10);
				hold(1'b0, 25);
			end else begin
				hold(1'b1, 25);
				hold(1'b0, 10);
			end
		end
	endtask

	// Whole frame, then acknowledge sample
	task automatic send_frame(input logic [7:0] addr, input logic [7:0] data,
		input logic bad, output logic ack);
		busy = 1'b1;
		send_byte(addr, 1'b0);
		hold(1'b1, 25);
		hold(1'b0, start_len);
		send_byte(data, bad);
		hold(1'b1, 25);
		busy = 1'b0;
		hold(1'b0, 2);
		ack = (line_in === 1'b0);
		for (int k = 0; k < 300 && line_in !== 1'b1; k++) begin
			@(negedge clk);
		end
		hold(1'b0, 30);
	endtask
endmodule // ops_host

// ---- verification/tb.sv ----
// Testbench for the one-pin voltage-set receiver
`timescale 1ns/1ps
module tb;
	import ops_pkg::*;
	localparam logic [12:0] TO_CYC = 13'h00C8;
	logic       clk, rst, en1, en2, apply_ready, ack;
	logic       host_low, pwm_lost, line_out, line_oe, forced_pwm, rx_ready;
	logic [4:0] conv1, conv2;
	int         errors, n_compared, cycles;
	wire        line_in = ~(host_low | (line_oe & ~line_out));

	////////////////////////////////////////////////////////////////////
	// Design, host model, clock
	ops_rx #(.DEV_ADDR(8'h5A), .TIMEOUT_CYC(TO_CYC), .ACK_PULSE_CYC(TO_CYC)) u_ops_rx (
		.clk(clk), .rst(rst), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
		.converter1_enable_pin(en1), .converter2_enable_pin(en2),
		.apply_ready(apply_ready), .forced_pwm(forced_pwm), .rx_ready(rx_ready),
		.conv1_voltage_setting(conv1), .conv2_voltage_setting(conv2));
	ops_host u_ops_host (.clk(clk), .line_in(line_in), .fpwm(forced_pwm),
		.host_low(host_low), .pwm_lost(pwm_lost));
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////
	// Checks and verdict
	task automatic complete_run();
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
			errors++;
		end
	endtask

	// One frame with acknowledge and mode checks
	task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic bad,
		input logic exp_ack);
		u_ops_host.send_frame(a, d, bad, ack);
		chk("ack", {7'h00, exp_ack}, {7'h00, ack});
		chk("pwm_lost", 8'h00, {7'h00, pwm_lost});
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		en1 = 1'b1;
		en2 = 1'b1;
		apply_ready = 1'b1;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (1690) @(negedge clk);
		chk("rx_ready", 8'h00, {7'h00, rx_ready});
		repeat (20) @(negedge clk);
		chk("rx_ready", 8'h01, {7'h00, rx_ready});
		chk("conv1", 8'h00, {3'h0, conv1});
		// Every select code; only 00 and 10 load a register
		for (int s = 0; s < 4; s++) begin
			frame(8'h5A, {1'b1, 2'(s), 5'(s + 9)}, 1'b0, 1'b1);
			chk("conv1", 8'h09, {3'h0, conv1});
			chk("conv2", (s >= 2) ? 8'h0B : 8'h00, {3'h0, conv2});
		end
		frame(8'h5A, 8'h5C, 1'b0, 1'b0);
		chk("conv2", 8'h1C, {3'h0, conv2});
		frame(8'hA5, 8'h9F, 1'b0, 1'b0);
		chk("conv1", 8'h09, {3'h0, conv1});
		frame(8'h5A, 8'h83, 1'b1, 1'b0);
		chk("conv1", 8'h09, {3'h0, conv1});
		// Short start before the data byte drops the frame
		u_ops_host.start_len = 10;
		frame(8'h5A, 8'h95, 1'b0, 1'b0);
		u_ops_host.start_len = 25;
		chk("conv1", 8'h09, {3'h0, conv1});
		// Long low enables power-save, high forces PWM at once
		u_ops_host.hold(1'b1, 190);
		chk("forced_pwm", 8'h01, {7'h00, forced_pwm});
		u_ops_host.hold(1'b1, 20);
		chk("forced_pwm", 8'h00, {7'h00, forced_pwm});
		u_ops_host.hold(1'b0, 0);
		#1;
		chk("forced_pwm", 8'h01, {7'h00, forced_pwm});
		repeat (30) @(negedge clk);
		// Stalled drain: queue fills, the extra frame is refused
		apply_ready = 1'b0;
		for (int i = 0; i < 17; i++) begin
			frame(8'h5A, {3'h4, 5'(i)}, 1'b0, i < 16);
		end
		chk("conv1", 8'h09, {3'h0, conv1});
		apply_ready = 1'b1;
		repeat (40) @(negedge clk);
		chk("conv1", 8'h0F, {3'h0, conv1});
		// Both enables low stops the receiver; one enable restarts it
		en1 = 1'b0;
		en2 = 1'b0;
		repeat (2) @(negedge clk);
		chk("rx_ready", 8'h00, {7'h00, rx_ready});
		en2 = 1'b1;
		repeat (1710) @(negedge clk);
		chk("rx_ready", 8'h01, {7'h00, rx_ready});
		frame(8'h5A, 8'hC4, 1'b0, 1'b1);
		chk("conv2", 8'h04, {3'h0, conv2});
		chk("conv1", 8'h0F, {3'h0, conv1});
		complete_run();
	end
endmodule // tb
